// [core/trig_qual_pkg.sv]
package trig_qual_pkg;
	// source counts and widths
	localparam int N_ANALOG = 16;
	localparam int N_LOGIC  = 8;
	localparam int N_MATH   = 16;
	localparam int N_SRC    = N_ANALOG + N_LOGIC + N_MATH;
	localparam int N_UNIT   = 5;
	localparam int ADDR_W   = 8;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_HOLDOFF = 8'h04;
	localparam logic [7:0] OFS_POSTDLY = 8'h08;
	localparam logic [7:0] OFS_ABDLY   = 8'h0C;
	localparam logic [7:0] OFS_COUNT   = 8'h10;
	localparam logic [7:0] OFS_PRE     = 8'h14;
	localparam logic [7:0] OFS_A_CARE  = 8'h18;
	localparam logic [7:0] OFS_A_VAL   = 8'h1C;
	localparam logic [7:0] OFS_A_HI    = 8'h20;
	localparam logic [7:0] OFS_B_CARE  = 8'h24;
	localparam logic [7:0] OFS_B_VAL   = 8'h28;
	localparam logic [7:0] OFS_B_HI    = 8'h2C;
	localparam logic [7:0] OFS_STATUS  = 8'h30;
	// control word field positions
	localparam int CTL_TYPE_LSB = 0;
	localparam int CTL_MODE_LSB = 3;
	localparam int CTL_DUAL     = 5;
	localparam int CTL_EXTCLK   = 6;
	localparam int CTL_RECORDER = 7;
	localparam int CTL_SYNC     = 8;
	localparam int CTL_TIME_SRC = 9;
	localparam int CTL_EXT_SRC  = 10;
	localparam int CTL_A_EXIT   = 11;
	localparam int CTL_B_EXIT   = 12;
	localparam int CTL_REARM    = 13;
	localparam int CTL_UNIT_LSB = 16;
	localparam int CTL_MASK_LSB = 20;
	// writable bits of each register
	localparam logic [31:0] CTRL_MASK  = 32'h01F71FFF;
	localparam logic [31:0] TIME_MASK  = 32'h3FFFFFFF;
	localparam logic [31:0] COUNT_MASK = 32'h00003FFF;
	localparam logic [31:0] PRE_MASK   = 32'h000003FF;
	localparam logic [31:0] HI_MASK    = 32'h0000FFFF;
	// reset values and limits
	localparam logic [31:0] RST_COUNT  = 32'h00000001;
	localparam logic [31:0] COUNT_MIN  = 32'h00000001;
	localparam logic [31:0] COUNT_MAX  = 32'h00002710;
	localparam logic [31:0] PRE_MAX    = 32'h000003E8;
	localparam logic [31:0] TIME_MAX   = 32'h3B9ACA00;
	// timing: one setting step is 0.01 us, clock period 8 ns
	localparam longint STEP_PS         = 10000;
	localparam longint CLK_PERIOD_PS   = 8000;
	localparam longint LONG_HOLDOFF_MS = 50;
	localparam logic [31:0] LONG_HO_UNITS =
		32'(LONG_HOLDOFF_MS * 64'd1000000000 / STEP_PS);
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		TT_SIMPLE = 3'b000,
		TT_PERIOD = 3'b001,
		TT_OR     = 3'b010,
		TT_AND    = 3'b011,
		TT_ATOB   = 3'b100,
		TT_ADLYB  = 3'b101,
		TT_LINE   = 3'b110
	} trig_type_t;

	typedef enum logic [1:0] {
		MODE_AUTO    = 2'b00,
		MODE_AUTOLVL = 2'b01,
		MODE_NORMAL  = 2'b10,
		MODE_SINGLE  = 2'b11
	} mode_t;

	typedef enum logic [2:0] {
		SEQ_WAIT_A  = 3'b000,
		SEQ_COUNT_B = 3'b001,
		SEQ_WAIT_B  = 3'b010,
		SEQ_DELAY   = 3'b011,
		SEQ_FIRE_A  = 3'b100
	} seq_t;

	// comparator results of all sources, one bit each
	typedef struct packed {
		logic [N_MATH-1:0]   realtime_math_channel;
		logic [N_LOGIC-1:0]  logic_bits;
		logic [N_ANALOG-1:0] analog;
	} src_lvl_t;

	typedef struct packed {
		logic        awready, wready, bvalid, arready, rvalid;
		logic [1:0]  bresp, rresp;
		logic [31:0] rdata;
		logic        aw_held, w_held;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic [31:0] ctrl, holdoff, postdly, abdly, count, pre;
		logic [31:0] a_care, a_val, a_hi, b_care, b_val, b_hi;
		logic [1:0]  logic_sync;
		logic        a_prev, b_prev;
		seq_t        seq;
		logic [13:0] bcnt;
		logic        ho_act, pd_act;
		logic [39:0] ho_cnt, ab_cnt, pd_cnt;
		logic        trig, capture, unavail;
		logic [9:0]  pre_out;
		mode_t       eff_mode;
	} state_t;
endpackage : trig_qual_pkg

// [core/trig_qual.sv]
`timescale 1ns/10ps
// Operation
// - hold-off blocks detections after a trigger
// - long hold-off honoured only in normal mode
// - sequenced types: hold-off gates condition B only
// - time source bypasses hold-off for some types
// - post-trigger delay shifts the capture point
// - external sample clock forces zero delay
// - stored delay kept across time scale changes
// - dual capture forces normal trigger mode
// - recorder pre-trigger ratio in tenth percent
// - sync operation picks trigger from units
// - some trigger types unavailable when synchronised
// - forty sources; logic bits need module present
// - per-source high, low or dont-care match
// - condition met on enter or exit edge
// - A then N times B fires trigger
// - count N from 1 to 10000, default 1
// - B, then delay, then first A fires
// - A-delay-B interval up to ten seconds
module trig_qual (
	input  wire logic                          CLK_SYS,
	input  wire logic                          RSTN,
	input  wire logic                          AWVALID,
	output logic                               AWREADY,
	input  wire logic [trig_qual_pkg::ADDR_W-1:0] AWADDR,
	input  wire logic                          WVALID,
	output logic                               WREADY,
	input  wire logic [31:0]                   WDATA,
	input  wire logic [3:0]                    WSTRB,
	output logic                               BVALID,
	input  wire logic                          BREADY,
	output logic [1:0]                         BRESP,
	input  wire logic                          ARVALID,
	output logic                               ARREADY,
	input  wire logic [trig_qual_pkg::ADDR_W-1:0] ARADDR,
	output logic                               RVALID,
	input  wire logic                          RREADY,
	output logic [31:0]                        RDATA,
	output logic [1:0]                         RRESP,
	input  wire trig_qual_pkg::src_lvl_t       SRC_LVL,
	input  wire logic                          LOGIC_PRESENT,
	input  wire logic                          RAW_TRIG,
	input  wire logic                          MANUAL_TRIG,
	input  wire logic [trig_qual_pkg::N_UNIT-1:0] UNIT_TRIG,
	output logic                               TRIG_OUT,
	output logic                               CAPTURE_OUT,
	output logic                               HOLDOFF_ACTIVE,
	output logic [9:0]                         PRE_RATIO,
	output trig_qual_pkg::mode_t               EFF_MODE
);

	////////////////////////////////////////////////////////////////////
	// state and decoded settings
	trig_qual_pkg::state_t     s;        // registered state
	trig_qual_pkg::state_t     nx;       // next state
	trig_qual_pkg::trig_type_t ctype;    // selected trigger type
	logic [trig_qual_pkg::N_SRC-1:0] lvl;      // source levels
	logic [trig_qual_pkg::N_SRC-1:0] avail;    // usable sources
	logic [trig_qual_pkg::N_SRC-1:0] care_a;   // A compare enables
	logic [trig_qual_pkg::N_SRC-1:0] care_b;   // B compare enables
	logic [trig_qual_pkg::N_SRC-1:0] val_a;    // A wanted levels
	logic [trig_qual_pkg::N_SRC-1:0] val_b;    // B wanted levels
	logic        match_a, match_b;  // pattern results
	logic        ev_a, ev_b;        // condition met events
	logic [31:0] ho_units;          // effective hold-off setting
	logic [39:0] ho_thr, ab_thr, pd_thr; // thresholds in ticks
	logic        bypass;            // hold-off bypass
	logic        suppress;          // hold-off blocks simple detection
	logic        raw;               // selected detection source
	logic        fire;              // trigger accepted this cycle
	logic        rearm;             // restart the sequence
	logic        sync_on;           // multi-unit operation
	logic [2:0]  unit_sel;          // single unit selection
	trig_qual_pkg::seq_t seq_start; // sequence start state

	assign lvl = SRC_LVL;

	////////////////////////////////////////////////////////////////////
	// helpers
	// byte-lane write merge, reserved bits cleared
	function automatic logic [31:0] wr(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] st,
		input logic [31:0] m);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r & m;
	endfunction : wr

	// 0.01 us steps to clock ticks, rounded down
	function automatic logic [39:0] ticks(input logic [31:0] u);
		return 40'((64'(u) * 64'(trig_qual_pkg::STEP_PS)) /
			64'(trig_qual_pkg::CLK_PERIOD_PS));
	endfunction : ticks

	// per-source availability: logic bits only with the module
	genvar g;
	generate
		for (g = 0; g < trig_qual_pkg::N_SRC; g++) begin : g_avail
			if (g >= trig_qual_pkg::N_ANALOG && g < trig_qual_pkg::N_ANALOG
				+ trig_qual_pkg::N_LOGIC) begin : g_lg
				assign avail[g] = s.logic_sync[1];
			end else begin : g_an
				assign avail[g] = 1'b1;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		nx = s;
		nx.logic_sync = {s.logic_sync[0], LOGIC_PRESENT};
		ctype = trig_qual_pkg::trig_type_t'(
			s.ctrl[trig_qual_pkg::CTL_TYPE_LSB +: 3]);
		sync_on = s.ctrl[trig_qual_pkg::CTL_SYNC];
		unit_sel = s.ctrl[trig_qual_pkg::CTL_UNIT_LSB +: 3];
		// dual capture overrides the selected mode
		if (s.ctrl[trig_qual_pkg::CTL_DUAL]) begin
			nx.eff_mode = trig_qual_pkg::MODE_NORMAL;
		end else begin
			nx.eff_mode = trig_qual_pkg::mode_t'(
				s.ctrl[trig_qual_pkg::CTL_MODE_LSB +: 2]);
		end
		nx.pre_out = s.pre[9:0];
		// state patterns: dont-care sources drop out of the match
		care_a = {s.a_hi[7:0], s.a_care} & avail;
		care_b = {s.b_hi[7:0], s.b_care} & avail;
		val_a = {s.a_hi[15:8], s.a_val};
		val_b = {s.b_hi[15:8], s.b_val};
		match_a = &(~care_a | ~(lvl ^ val_a));
		match_b = &(~care_b | ~(lvl ^ val_b));
		// enter is false-to-true, exit is true-to-false
		ev_a = s.ctrl[trig_qual_pkg::CTL_A_EXIT] ?
			(s.a_prev & ~match_a) : (~s.a_prev & match_a);
		ev_b = s.ctrl[trig_qual_pkg::CTL_B_EXIT] ?
			(s.b_prev & ~match_b) : (~s.b_prev & match_b);
		nx.a_prev = match_a;
		nx.b_prev = match_b;
		// long hold-off dropped outside normal mode
		ho_units = s.holdoff;
		if (ho_units >= trig_qual_pkg::LONG_HO_UNITS &&
			s.eff_mode != trig_qual_pkg::MODE_NORMAL) begin
			ho_units = 32'h00000000;
		end
		ho_thr = ticks(ho_units);
		ab_thr = ticks(s.abdly);
		// the stored value is never rewritten by time scale changes
		pd_thr = s.ctrl[trig_qual_pkg::CTL_EXTCLK] ?
			40'h0000000000 : ticks(s.postdly);
		// time source skips hold-off for simple, period and manual
		bypass = s.ctrl[trig_qual_pkg::CTL_TIME_SRC] &
			(ctype == trig_qual_pkg::TT_SIMPLE |
			 ctype == trig_qual_pkg::TT_PERIOD | MANUAL_TRIG);
		suppress = s.ho_act & ~bypass;
		// types not allowed while synchronised
		nx.unavail = sync_on & (s.ctrl[trig_qual_pkg::CTL_RECORDER] ?
			(ctype == trig_qual_pkg::TT_AND) :
			(ctype != trig_qual_pkg::TT_SIMPLE &
			 ctype != trig_qual_pkg::TT_OR));
		// detection source: own comparator or selected units
		if (!sync_on) begin
			raw = RAW_TRIG;
		end else if (ctype == trig_qual_pkg::TT_OR) begin
			raw = |(UNIT_TRIG &
				s.ctrl[trig_qual_pkg::CTL_MASK_LSB +:
				trig_qual_pkg::N_UNIT]);
		end else if (s.ctrl[trig_qual_pkg::CTL_TIME_SRC] |
			s.ctrl[trig_qual_pkg::CTL_EXT_SRC]) begin
			raw = UNIT_TRIG[0];
		end else if (32'(unit_sel) < trig_qual_pkg::N_UNIT) begin
			raw = UNIT_TRIG[unit_sel];
		end else begin
			raw = 1'b0;
		end
		seq_start = (ctype == trig_qual_pkg::TT_ADLYB) ?
			trig_qual_pkg::SEQ_WAIT_B : trig_qual_pkg::SEQ_WAIT_A;
		fire = 1'b0;
		// sequenced trigger state machine
		case (ctype)
			trig_qual_pkg::TT_ATOB: begin
				case (s.seq)
					trig_qual_pkg::SEQ_WAIT_A: begin
						// A is never gated by hold-off
						if (ev_a) begin
							nx.seq = trig_qual_pkg::SEQ_COUNT_B;
							nx.bcnt = 14'h0000;
						end
					end
					trig_qual_pkg::SEQ_COUNT_B: begin
						if (ev_b && !s.ho_act) begin
							if (32'(s.bcnt) + 32'h1 >= s.count) begin
								fire = 1'b1;
							end else begin
								nx.bcnt = s.bcnt + 14'h0001;
							end
						end
					end
					default: begin
						nx.seq = seq_start;
					end
				endcase
			end
			trig_qual_pkg::TT_ADLYB: begin
				case (s.seq)
					trig_qual_pkg::SEQ_WAIT_B: begin
						if (ev_b && !s.ho_act) begin
							nx.ab_cnt = 40'h0000000000;
							nx.seq = (ab_thr == 40'h0000000000) ?
								trig_qual_pkg::SEQ_FIRE_A :
								trig_qual_pkg::SEQ_DELAY;
						end
					end
					trig_qual_pkg::SEQ_DELAY: begin
						nx.ab_cnt = s.ab_cnt + 40'h0000000001;
						if (s.ab_cnt + 40'h0000000001 >= ab_thr) begin
							nx.seq = trig_qual_pkg::SEQ_FIRE_A;
						end
					end
					trig_qual_pkg::SEQ_FIRE_A: begin
						fire = ev_a;
					end
					default: begin
						nx.seq = seq_start;
					end
				endcase
			end
			default: begin
				fire = raw & ~suppress;
			end
		endcase
		// manual trigger respects hold-off unless bypassed
		if (MANUAL_TRIG && (!s.ho_act || bypass)) begin
			fire = 1'b1;
		end
		fire = fire & ~nx.unavail & ~s.unavail;
		nx.trig = fire;
		// hold-off timer, restarted by each accepted trigger
		if (fire) begin
			nx.ho_cnt = 40'h0000000000;
			nx.ho_act = (ho_thr != 40'h0000000000);
		end else if (s.ho_act) begin
			nx.ho_cnt = s.ho_cnt + 40'h0000000001;
			if (s.ho_cnt + 40'h0000000001 >= ho_thr) begin
				nx.ho_act = 1'b0;
			end
		end
		// post-trigger delay: capture point moved later
		nx.capture = 1'b0;
		if (fire) begin
			nx.pd_cnt = 40'h0000000000;
			nx.pd_act = (pd_thr != 40'h0000000000);
			nx.capture = (pd_thr == 40'h0000000000);
		end else if (s.pd_act) begin
			nx.pd_cnt = s.pd_cnt + 40'h0000000001;
			if (s.pd_cnt + 40'h0000000001 >= pd_thr) begin
				nx.pd_act = 1'b0;
				nx.capture = 1'b1;
			end
		end
		// axi write channel
		if (s.bvalid && BREADY) begin
			nx.bvalid = 1'b0;
		end
		if (AWVALID && s.awready) begin
			nx.aw_held = 1'b1;
			nx.awaddr = AWADDR;
		end
		if (WVALID && s.wready) begin
			nx.w_held = 1'b1;
			nx.wdata = WDATA;
			nx.wstrb = WSTRB;
		end
		rearm = 1'b0;
		if (s.aw_held && s.w_held) begin
			nx.aw_held = 1'b0;
			nx.w_held = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = trig_qual_pkg::RESP_OKAY;
			case (s.awaddr)
				trig_qual_pkg::OFS_CTRL: begin
					nx.ctrl = wr(s.ctrl, s.wdata, s.wstrb,
						trig_qual_pkg::CTRL_MASK);
					rearm = s.wstrb[1] &
						s.wdata[trig_qual_pkg::CTL_REARM];
				end
				trig_qual_pkg::OFS_HOLDOFF: nx.holdoff = wr(s.holdoff,
					s.wdata, s.wstrb, trig_qual_pkg::TIME_MASK);
				trig_qual_pkg::OFS_POSTDLY: nx.postdly = wr(s.postdly,
					s.wdata, s.wstrb, trig_qual_pkg::TIME_MASK);
				trig_qual_pkg::OFS_ABDLY: nx.abdly = wr(s.abdly,
					s.wdata, s.wstrb, trig_qual_pkg::TIME_MASK);
				trig_qual_pkg::OFS_COUNT: nx.count = wr(s.count,
					s.wdata, s.wstrb, trig_qual_pkg::COUNT_MASK);
				trig_qual_pkg::OFS_PRE: nx.pre = wr(s.pre,
					s.wdata, s.wstrb, trig_qual_pkg::PRE_MASK);
				trig_qual_pkg::OFS_A_CARE: nx.a_care = wr(s.a_care,
					s.wdata, s.wstrb, 32'hFFFFFFFF);
				trig_qual_pkg::OFS_A_VAL: nx.a_val = wr(s.a_val,
					s.wdata, s.wstrb, 32'hFFFFFFFF);
				trig_qual_pkg::OFS_A_HI: nx.a_hi = wr(s.a_hi,
					s.wdata, s.wstrb, trig_qual_pkg::HI_MASK);
				trig_qual_pkg::OFS_B_CARE: nx.b_care = wr(s.b_care,
					s.wdata, s.wstrb, 32'hFFFFFFFF);
				trig_qual_pkg::OFS_B_VAL: nx.b_val = wr(s.b_val,
					s.wdata, s.wstrb, 32'hFFFFFFFF);
				trig_qual_pkg::OFS_B_HI: nx.b_hi = wr(s.b_hi,
					s.wdata, s.wstrb, trig_qual_pkg::HI_MASK);
				default: nx.bresp = trig_qual_pkg::RESP_SLVERR;
			endcase
		end
		// settings held inside their legal ranges
		if (nx.count < trig_qual_pkg::COUNT_MIN) begin
			nx.count = trig_qual_pkg::COUNT_MIN;
		end else if (nx.count > trig_qual_pkg::COUNT_MAX) begin
			nx.count = trig_qual_pkg::COUNT_MAX;
		end
		if (nx.pre > trig_qual_pkg::PRE_MAX) begin
			nx.pre = trig_qual_pkg::PRE_MAX;
		end
		if (nx.holdoff > trig_qual_pkg::TIME_MAX) begin
			nx.holdoff = trig_qual_pkg::TIME_MAX;
		end
		if (nx.postdly > trig_qual_pkg::TIME_MAX) begin
			nx.postdly = trig_qual_pkg::TIME_MAX;
		end
		if (nx.abdly > trig_qual_pkg::TIME_MAX) begin
			nx.abdly = trig_qual_pkg::TIME_MAX;
		end
		// fire, rearm or type change restarts the sequence
		if (fire || rearm || nx.ctrl[2:0] != s.ctrl[2:0]) begin
			nx.bcnt = 14'h0000;
			nx.seq = (nx.ctrl[2:0] == trig_qual_pkg::TT_ADLYB) ?
				trig_qual_pkg::SEQ_WAIT_B : trig_qual_pkg::SEQ_WAIT_A;
		end
		nx.awready = ~nx.aw_held & ~nx.bvalid;
		nx.wready = ~nx.w_held & ~nx.bvalid;
		// axi read channel, answer one cycle after the address
		if (s.rvalid && RREADY) begin
			nx.rvalid = 1'b0;
		end
		if (ARVALID && s.arready) begin
			nx.rvalid = 1'b1;
			nx.rresp = trig_qual_pkg::RESP_OKAY;
			case (ARADDR)
				trig_qual_pkg::OFS_CTRL:    nx.rdata = s.ctrl;
				trig_qual_pkg::OFS_HOLDOFF: nx.rdata = s.holdoff;
				trig_qual_pkg::OFS_POSTDLY: nx.rdata = s.postdly;
				trig_qual_pkg::OFS_ABDLY:   nx.rdata = s.abdly;
				trig_qual_pkg::OFS_COUNT:   nx.rdata = s.count;
				trig_qual_pkg::OFS_PRE:     nx.rdata = s.pre;
				trig_qual_pkg::OFS_A_CARE:  nx.rdata = s.a_care;
				trig_qual_pkg::OFS_A_VAL:   nx.rdata = s.a_val;
				trig_qual_pkg::OFS_A_HI:    nx.rdata = s.a_hi;
				trig_qual_pkg::OFS_B_CARE:  nx.rdata = s.b_care;
				trig_qual_pkg::OFS_B_VAL:   nx.rdata = s.b_val;
				trig_qual_pkg::OFS_B_HI:    nx.rdata = s.b_hi;
				trig_qual_pkg::OFS_STATUS:  nx.rdata = {9'h000,
					s.logic_sync[1], s.pd_act, s.ho_act, s.unavail,
					s.eff_mode, s.seq, s.bcnt};
				default: begin
					nx.rdata = 32'h00000000;
					nx.rresp = trig_qual_pkg::RESP_SLVERR;
				end
			endcase
		end
		nx.arready = ~nx.rvalid;
	end

	////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			s <= '0;
			s.count <= trig_qual_pkg::RST_COUNT;
		end else begin
			s <= nx;
		end
	end

	// outputs straight from the state register
	assign AWREADY = s.awready;
	assign WREADY = s.wready;
	assign BVALID = s.bvalid;
	assign BRESP = s.bresp;
	assign ARREADY = s.arready;
	assign RVALID = s.rvalid;
	assign RDATA = s.rdata;
	assign RRESP = s.rresp;
	assign TRIG_OUT = s.trig;
	assign CAPTURE_OUT = s.capture;
	assign HOLDOFF_ACTIVE = s.ho_act;
	assign PRE_RATIO = s.pre_out;
	assign EFF_MODE = s.eff_mode;

	////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	dual_normal_a: assert property (
		s.ctrl[trig_qual_pkg::CTL_DUAL] |=>
		EFF_MODE == trig_qual_pkg::MODE_NORMAL)
		else $error("dual capture did not force normal mode");
	holdoff_block_a: assert property (
		s.ho_act && ctype == trig_qual_pkg::TT_SIMPLE &&
		!s.ctrl[trig_qual_pkg::CTL_TIME_SRC] && !MANUAL_TRIG |=>
		!TRIG_OUT)
		else $error("trigger accepted during hold-off");
	holdoff_start_a: assert property (
		fire && ho_thr != 40'h0000000000 |=>
		HOLDOFF_ACTIVE && TRIG_OUT && s.ho_cnt == 40'h0000000000)
		else $error("hold-off did not restart on trigger");
	long_holdoff_a: assert property (
		TRIG_OUT && $past(EFF_MODE) != trig_qual_pkg::MODE_NORMAL &&
		$past(s.holdoff) >= trig_qual_pkg::LONG_HO_UNITS |->
		!HOLDOFF_ACTIVE)
		else $error("long hold-off applied outside normal mode");
	bypass_time_a: assert property (
		s.ho_act && ctype == trig_qual_pkg::TT_SIMPLE && !sync_on &&
		s.ctrl[trig_qual_pkg::CTL_TIME_SRC] && RAW_TRIG &&
		!s.unavail && !nx.unavail |=> TRIG_OUT)
		else $error("time source did not bypass hold-off");
	atob_count_a: assert property (
		TRIG_OUT && $past(ctype == trig_qual_pkg::TT_ATOB) &&
		!$past(MANUAL_TRIG) |->
		$past(s.seq) == trig_qual_pkg::SEQ_COUNT_B &&
		32'($past(s.bcnt)) + 32'h1 >= $past(s.count))
		else $error("A to B fired before N occurrences");
	b_gated_a: assert property (
		ctype == trig_qual_pkg::TT_ATOB && s.ho_act && !MANUAL_TRIG &&
		s.seq == trig_qual_pkg::SEQ_COUNT_B && !(s.aw_held && s.w_held) |=>
		s.bcnt == $past(s.bcnt) && !TRIG_OUT)
		else $error("condition B counted during hold-off");
	seq_clear_a: assert property (
		TRIG_OUT |-> s.bcnt == 14'h0000)
		else $error("B counter not cleared on trigger");
	adlyb_order_a: assert property (
		TRIG_OUT && $past(ctype == trig_qual_pkg::TT_ADLYB) &&
		!$past(MANUAL_TRIG) |->
		$past(s.seq) == trig_qual_pkg::SEQ_FIRE_A)
		else $error("A delay B fired before delay elapsed");
	extclk_zero_a: assert property (
		fire && s.ctrl[trig_qual_pkg::CTL_EXTCLK] |=> CAPTURE_OUT)
		else $error("post delay applied with external clock");
	unavail_a: assert property (
		s.unavail |=> !TRIG_OUT)
		else $error("unavailable trigger type fired");
	count_range_a: assert property (
		s.count >= trig_qual_pkg::COUNT_MIN &&
		s.count <= trig_qual_pkg::COUNT_MAX)
		else $error("count setting out of range");

	atob_fire_c: cover property (
		s.seq == trig_qual_pkg::SEQ_COUNT_B ##1 TRIG_OUT);
	adlyb_fire_c: cover property (
		s.seq == trig_qual_pkg::SEQ_DELAY ##[1:50] TRIG_OUT);
	holdoff_hit_c: cover property (s.ho_act && RAW_TRIG);
	late_capture_c: cover property (TRIG_OUT ##[2:50] CAPTURE_OUT);

endmodule : trig_qual

// [tb/tb_sequenced_trigger_qualifier.sv]
`timescale 1ns/10ps
module tb_sequenced_trigger_qualifier;
	logic        CLK_SYS = 0, RSTN = 0, RAW_TRIG = 0, MANUAL_TRIG = 0;
	logic        AWVALID = 0, WVALID = 0, ARVALID = 0;
	logic        BREADY = 1, RREADY = 1;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic        TRIG_OUT, CAPTURE_OUT, HOLDOFF_ACTIVE;
	logic [7:0]  AWADDR = 0, ARADDR = 0;
	logic [31:0] WDATA = 0, RDATA, v;
	logic [1:0]  BRESP, RRESP;
	logic [9:0]  PRE_RATIO;
	trig_qual_pkg::src_lvl_t SRC_LVL = '0;
	trig_qual_pkg::mode_t    EFF_MODE;
	int          n_mismatch = 0, num_checks = 0, ntrig = 0, d, t;
	int          cyc = 0, tlast = 0, nho = 0, h; // cycle and level counts
	logic [33:0] expq[$]; // expected {resp, data} of each read
	logic [1:0]  expb[$]; // expected response of each write
	int          expc[$]; // expected capture lag after a trigger
	//////////////////////////////////////////////////////////////
	trig_qual trig_qual_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
		.WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(4'hF),
		.BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
		.RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
		.SRC_LVL(SRC_LVL), .LOGIC_PRESENT(1'b1), .RAW_TRIG(RAW_TRIG),
		.MANUAL_TRIG(MANUAL_TRIG), .UNIT_TRIG(5'h00), .TRIG_OUT(TRIG_OUT),
		.CAPTURE_OUT(CAPTURE_OUT), .HOLDOFF_ACTIVE(HOLDOFF_ACTIVE),
		.PRE_RATIO(PRE_RATIO), .EFF_MODE(EFF_MODE));
	// 125 MHz clock
	always #4 CLK_SYS = ~CLK_SYS;
	//////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [33:0] seen,
		input logic [33:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// a wait that ran out ends the run
	task hang;
		n_mismatch++;
		tally_and_finish();
	endtask : hang
	task automatic tick(input int k);
		repeat (k) @(posedge CLK_SYS);
	endtask : tick
	// write: address and data offered together, each dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] dt);
		int n = 0;
		// only the aligned offsets of the writable registers answer okay
		expb.push_back((a <= trig_qual_pkg::OFS_B_HI && a[1:0] == 2'h0) ?
			trig_qual_pkg::RESP_OKAY : trig_qual_pkg::RESP_SLVERR);
		AWADDR <= a;
		WDATA <= dt;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			n++;
			if (AWREADY === 1'b1) AWVALID <= 1'b0;
			if (WREADY === 1'b1) WVALID <= 1'b0;
		end while (BVALID !== 1'b1 && n < 50);
		if (BVALID !== 1'b1) hang();
	endtask : axw
	// read: the expectation is noted, the monitor compares it
	task automatic axr(input logic [7:0] a, input logic [33:0] e);
		int n = 0;
		expq.push_back(e);
		ARADDR <= a;
		ARVALID <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			n++;
			if (ARREADY === 1'b1) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1 && n < 50);
		if (RVALID !== 1'b1) hang();
	endtask : axr
	// one raw detection pulse, or one manual request
	task automatic pulse(input logic man);
		RAW_TRIG <= ~man;
		MANUAL_TRIG <= man;
		tick(1);
		RAW_TRIG <= 1'b0;
		MANUAL_TRIG <= 1'b0;
	endtask : pulse
	// two detections three cycles apart, count accepted triggers
	task automatic burst(input logic [31:0] ctl, input logic man,
		output int dn);
		int t0;
		axw(trig_qual_pkg::OFS_CTRL, ctl);
		t0 = ntrig;
		pulse(man);
		tick(2);
		pulse(man);
		tick(3);
		dn = ntrig - t0;
	endtask : burst
	// analog sources high for two cycles, then low
	task automatic src(input logic [15:0] m);
		SRC_LVL.analog <= m;
		tick(2);
		SRC_LVL.analog <= 16'h0000;
		tick(2);
	endtask : src
	//////////////////////////////////////////////////////////////
	// monitor: read answers against notes, trigger pulses counted
	always @(posedge CLK_SYS) begin
		cyc++;
		if (RVALID === 1'b1) begin
			chk("read", {RRESP, RDATA}, expq.pop_front());
		end
		if (BVALID === 1'b1) begin
			chk("bresp", {32'h0, BRESP}, expb.pop_front());
		end
		if (TRIG_OUT === 1'b1) begin
			ntrig++;
			tlast = cyc;
		end
		if (HOLDOFF_ACTIVE === 1'b1) nho++;
		// capture lag is checked while a note is waiting
		if (CAPTURE_OUT === 1'b1 && expc.size() > 0) begin
			chk("capture lag", cyc - tlast, expc.pop_front());
		end
	end
	initial begin
		v = $urandom(44409);
		tick(5);
		RSTN <= 1'b1;
		tick(1);
		axr(trig_qual_pkg::OFS_COUNT, 34'h000000001);
		axr(trig_qual_pkg::OFS_HOLDOFF, 34'h0);
		axr(8'h40, {trig_qual_pkg::RESP_SLVERR, 32'h0});
		axw(8'h40, 32'h0);
		axw(trig_qual_pkg::OFS_COUNT, 32'h0);
		axr(trig_qual_pkg::OFS_COUNT, 34'h000000001);
		axw(trig_qual_pkg::OFS_COUNT, 32'h0000FFFF);
		axr(trig_qual_pkg::OFS_COUNT, 34'h000002710);
		v = $urandom % 1001;
		axw(trig_qual_pkg::OFS_PRE, v);
		axr(trig_qual_pkg::OFS_PRE, {2'h0, v});
		chk("pre", PRE_RATIO, v);
		// dual capture on, auto mode asked for
		axw(trig_qual_pkg::OFS_CTRL, 32'h00000020);
		tick(2);
		chk("mode", EFF_MODE, trig_qual_pkg::MODE_NORMAL);
		// hold-off of five ticks, normal mode
		axw(trig_qual_pkg::OFS_HOLDOFF, 32'h00000004);
		h = nho;
		burst(32'h00000010, 1'b0, d);
		chk("holdoff", d, 1);
		// four steps of 10 ns at 8 ns a tick give five ticks
		chk("holdoff len", nho - h, 5);
		burst(32'h00000210, 1'b0, d);
		chk("bypass", d, 2);
		// manual requests: held off, unless the time source is chosen
		burst(32'h00000010, 1'b1, d);
		chk("manual", d, 1);
		burst(32'h00000210, 1'b1, d);
		chk("manual bypass", d, 2);
		axw(trig_qual_pkg::OFS_HOLDOFF, trig_qual_pkg::LONG_HO_UNITS);
		burst(32'h00000000, 1'b0, d);
		chk("long", d, 2);
		// capture five ticks after the trigger, none with external clock
		axw(trig_qual_pkg::OFS_POSTDLY, 32'h00000004);
		expc.push_back(5);
		pulse(1'b0);
		tick(8);
		axw(trig_qual_pkg::OFS_CTRL, 32'h00000040);
		expc.push_back(0);
		pulse(1'b0);
		tick(3);
		chk("capture left", expc.size(), 0);
		// A on analog 0, B on analog 1, B three times
		axw(trig_qual_pkg::OFS_HOLDOFF, 32'h0);
		axw(trig_qual_pkg::OFS_A_CARE, 32'h1);
		axw(trig_qual_pkg::OFS_A_VAL, 32'h1);
		axw(trig_qual_pkg::OFS_B_CARE, 32'h2);
		axw(trig_qual_pkg::OFS_B_VAL, 32'h2);
		axw(trig_qual_pkg::OFS_COUNT, 32'h3);
		axw(trig_qual_pkg::OFS_CTRL, 32'h00000014);
		t = ntrig;
		src(2);
		src(1);
		src(2);
		src(2);
		chk("a2b", ntrig, t);
		src(2);
		src(2);
		chk("a2b", ntrig, t + 1);
		// B then A inside the delay, then A after it
		axw(trig_qual_pkg::OFS_ABDLY, 32'h4);
		axw(trig_qual_pkg::OFS_CTRL, 32'h00000015);
		t = ntrig;
		src(2);
		src(1);
		chk("adly", ntrig, t);
		tick(8);
		src(1);
		chk("adly", ntrig, t + 1);
		tally_and_finish();
	end
endmodule : tb_sequenced_trigger_qualifier
